// File: rtl/trs_params.svh
// Constants of the replay trigger selector: offsets, codes, reset values, timing.
// How it works
// R1: The mode register accepts exactly four codes: free run and rising, falling or either edge.
// R2: In free-run mode replay begins once start has been given and the setup delay has elapsed.
// R3: Writing force code 16 to the command word while waiting makes a trigger, base version 7 up.
// R4: With connector direction 0 the connector is unused and its driver is off.
// R5: With direction 1 in free-run mode the connector is driven and marks each internal trigger.
// R6: The trigger output is active high and pulses in the cycle replay begins.
// R7: Any edge mode turns the connector into an input whatever the direction setting holds.
// R8: In an edge mode the termination bit selects 50 ohm, otherwise the input stays high impedance.
// R9: Rising mode triggers on the first rising edge seen after start; the code ignores edges during setup and takes the first one once armed.
// R10: After a trigger all edges are ignored until replay is done and the block is armed again.
// R11: Falling mode triggers on the first falling edge seen after start; the code ignores edges during setup and takes the first one once armed.
// R12: Either-edge mode triggers on whichever edge comes first.
// R13: An incoming trigger is never passed back out on the connector.
// R14: Sharing one trigger among boards needs an external splitter feeding each connector.
// R15: A force command while not waiting for a trigger is ignored and makes no event.
// R16: The trigger input is synchronised to the clock and edges come from successive samples.
`ifndef TRS_PARAMS_SVH
`define TRS_PARAMS_SVH

// ==========================================================
// Register offsets
`define TRS_REG_COMMAND 32'h0000_0000
`define TRS_REG_MODE 32'h0000_9C40
`define TRS_REG_DIRECTION 32'h0000_9CA4
`define TRS_REG_TERMINATION 32'h0000_9CAE

// ==========================================================
// Mode and command codes
// Free-run code is not fixed elsewhere; plain default
`define TRS_CODE_FREE_RUN 32'h0000_0000
`define TRS_CODE_RISING 32'h0000_4E20
`define TRS_CODE_FALLING 32'h0000_4E2A
`define TRS_CODE_EITHER 32'h0000_4E3E
`define TRS_CMD_FORCE 32'h0000_0010
`define TRS_FORCE_MIN_VERSION 8'h07

// ==========================================================
// Reset values and timing
`define TRS_DIRECTION_RESET 1'b0
`define TRS_TERMINATION_RESET 1'b0
`define TRS_CLK_PERIOD_NS 10
`define TRS_SETUP_NS 40
`define TRS_SETUP_CYCLES ((`TRS_SETUP_NS + `TRS_CLK_PERIOD_NS - 1) / `TRS_CLK_PERIOD_NS)

`endif

// File: rtl/trs_pkg.sv
// Types shared by the replay trigger selector files.
`default_nettype none
package trs_pkg;

    typedef enum logic [1:0] {TRS_FREE_RUN, TRS_RISING, TRS_FALLING, TRS_EITHER} trs_mode_t;

    typedef enum logic [1:0] {TRS_IDLE, TRS_SETUP, TRS_ARMED, TRS_RUN} trs_state_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } trs_edge_t;

endpackage
`default_nettype wire

// File: rtl/trs_edge_det.sv
// Synchroniser and edge detector for the external trigger input.
`timescale 1ns/100ps
`default_nettype none
module trs_edge_det
    import trs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output var trs_pkg::trs_edge_t edges
);
    import trs_pkg::*;

    logic meta_ff, sync_ff, prev_ff;
    logic nxt_meta, nxt_sync, nxt_prev;

    // ==========================================================
    // Two-stage sync, third stage for comparison
    always_comb
    begin
        nxt_meta = din;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= nxt_meta; // [R16]
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    assign edges.rise = sync_ff & ~prev_ff; // [R16]
    assign edges.fall = ~sync_ff & prev_ff; // [R16]

endmodule // trs_edge_det
`default_nettype wire

// File: rtl/trs_trigger_select.sv
// Top of the replay trigger selector: registers, arming sequence and connector control.
`timescale 1ns/100ps
`default_nettype none
`include "trs_params.svh"
module trs_trigger_select
    import trs_pkg::*;
#(
    parameter int SETUP_CYCLES = `TRS_SETUP_CYCLES
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic [7:0] BASE_VERSION,
    input wire logic START,
    input wire logic REPLAY_DONE,
    input wire logic TRIG_IN,
    output logic TRIG_OUT,
    output logic TRIG_OE,
    output logic TERM_50_EN,
    output logic REPLAY_GO,
    output logic ARMED
);
    import trs_pkg::*;

    localparam int CW = (SETUP_CYCLES > 1) ? $clog2(SETUP_CYCLES) : 1;
    localparam logic [CW-1:0] SETUP_LAST = CW'(SETUP_CYCLES - 1);

    trs_edge_t edges;
    trs_mode_t mode_ff, nxt_mode;
    trs_state_t state_ff, nxt_state;
    logic dir_ff, nxt_dir;
    logic term_ff, nxt_term;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic go_ff, nxt_go;
    logic out_ff, nxt_out;
    logic oe_ff, nxt_oe;
    logic ten_ff, nxt_ten;
    logic armed_ff, nxt_armed;
    logic [31:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic force_wr, ext_mode, edge_hit, soft_mode;

    trs_edge_det u_edge
    (
        .clk(CLK),
        .reset(RESET),
        .din(TRIG_IN),
        .edges(edges)
    );

    // ==========================================================
    // Register file
    always_comb
    begin
        nxt_mode = mode_ff;
        nxt_dir = dir_ff;
        nxt_term = term_ff;
        if (REG_WR && REG_ADDR == `TRS_REG_MODE)
        begin
            // Unknown codes keep the old mode rather than leaving it undefined
            unique case (REG_WDATA)
                `TRS_CODE_FREE_RUN: nxt_mode = TRS_FREE_RUN; // [R1]
                `TRS_CODE_RISING: nxt_mode = TRS_RISING; // [R1]
                `TRS_CODE_FALLING: nxt_mode = TRS_FALLING; // [R1]
                `TRS_CODE_EITHER: nxt_mode = TRS_EITHER; // [R1]
                default: nxt_mode = mode_ff;
            endcase
        end
        if (REG_WR && REG_ADDR == `TRS_REG_DIRECTION)
            nxt_dir = REG_WDATA[0];
        if (REG_WR && REG_ADDR == `TRS_REG_TERMINATION)
            nxt_term = REG_WDATA[0];
        nxt_rvalid = REG_RD;
        nxt_rdata = 32'h0000_0000;
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                `TRS_REG_MODE:
                begin
                    unique case (mode_ff)
                        TRS_FREE_RUN: nxt_rdata = `TRS_CODE_FREE_RUN;
                        TRS_RISING: nxt_rdata = `TRS_CODE_RISING;
                        TRS_FALLING: nxt_rdata = `TRS_CODE_FALLING;
                        TRS_EITHER: nxt_rdata = `TRS_CODE_EITHER;
                    endcase
                end
                `TRS_REG_DIRECTION: nxt_rdata = {31'h0000_0000, dir_ff};
                `TRS_REG_TERMINATION: nxt_rdata = {31'h0000_0000, term_ff};
                // Commands are actions; the word reads back zero
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            mode_ff <= TRS_FREE_RUN;
            dir_ff <= `TRS_DIRECTION_RESET;
            term_ff <= `TRS_TERMINATION_RESET;
            rdata_ff <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            dir_ff <= nxt_dir;
            term_ff <= nxt_term;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // ==========================================================
    // Arming sequence and trigger decision
    assign soft_mode = (mode_ff == TRS_FREE_RUN);
    assign ext_mode = !soft_mode;
    assign force_wr = REG_WR && REG_ADDR == `TRS_REG_COMMAND && REG_WDATA == `TRS_CMD_FORCE
                      && BASE_VERSION >= `TRS_FORCE_MIN_VERSION; // [R3]

    always_comb
    begin
        unique case (mode_ff)
            TRS_RISING: edge_hit = edges.rise; // [R9]
            TRS_FALLING: edge_hit = edges.fall; // [R11]
            TRS_EITHER: edge_hit = edges.rise | edges.fall; // [R12]
            TRS_FREE_RUN: edge_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_go = 1'b0;
        unique case (state_ff)
            TRS_IDLE:
            begin
                if (START)
                begin
                    nxt_state = TRS_SETUP;
                    nxt_cnt = SETUP_LAST;
                end
            end
            TRS_SETUP:
            begin
                if (cnt_ff != '0)
                    nxt_cnt = cnt_ff - CW'(1);
                else if (soft_mode)
                begin
                    nxt_state = TRS_RUN; // [R2]
                    nxt_go = 1'b1;
                end
                else
                    nxt_state = TRS_ARMED;
            end
            TRS_ARMED:
            begin
                // Force only counts here; elsewhere it is dropped
                if (edge_hit || force_wr) // [R3] [R15]
                begin
                    nxt_state = TRS_RUN;
                    nxt_go = 1'b1;
                end
            end
            TRS_RUN:
            begin
                // Edges are not looked at until the block is armed again after the next start and setup
                if (REPLAY_DONE) // [R10]
                    nxt_state = TRS_IDLE;
            end
        endcase
        nxt_armed = (nxt_state == TRS_ARMED);
        nxt_oe = dir_ff && soft_mode; // [R4] [R5] [R7] [R13]
        nxt_out = nxt_go && nxt_oe && soft_mode; // [R5] [R6]
        nxt_ten = ext_mode && term_ff; // [R8]
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            state_ff <= TRS_IDLE;
            cnt_ff <= '0;
            go_ff <= 1'b0;
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
            ten_ff <= 1'b0;
            armed_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            go_ff <= nxt_go;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            ten_ff <= nxt_ten;
            armed_ff <= nxt_armed;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign REG_RVALID = rvalid_ff;
    assign TRIG_OUT = out_ff;
    assign TRIG_OE = oe_ff;
    assign TERM_50_EN = ten_ff;
    assign REPLAY_GO = go_ff;
    assign ARMED = armed_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_soft_setup_go: assert property ( // [R2]
        state_ff == TRS_SETUP && cnt_ff == '0 && soft_mode |=> go_ff && state_ff == TRS_RUN)
        else $error("free run did not start after setup");
    a_rise_edge_go: assert property ( // [R9]
        state_ff == TRS_ARMED && mode_ff == TRS_RISING && edges.rise |=> go_ff)
        else $error("rising edge missed");
    a_fall_edge_go: assert property ( // [R11]
        state_ff == TRS_ARMED && mode_ff == TRS_FALLING && edges.fall |=> go_ff)
        else $error("falling edge missed");
    a_either_edge_go: assert property ( // [R12]
        state_ff == TRS_ARMED && mode_ff == TRS_EITHER && (edges.rise || edges.fall)
        |=> go_ff)
        else $error("either edge missed");
    a_force_armed_go: assert property ( // [R3]
        state_ff == TRS_ARMED && force_wr |=> go_ff)
        else $error("force trigger lost");
    a_force_idle_drop: assert property ( // [R15]
        state_ff != TRS_ARMED && state_ff != TRS_SETUP && force_wr |=> !go_ff)
        else $error("force outside wait made an event");
    a_run_no_retrig: assert property ( // [R10]
        state_ff == TRS_RUN |=> !go_ff)
        else $error("trigger while running");
    a_out_only_internal: assert property ( // [R5] [R6] [R13]
        TRIG_OUT |-> REPLAY_GO && TRIG_OE && $past(soft_mode))
        else $error("trigger output without internal trigger");
    a_oe_direction: assert property ( // [R4] [R7]
        TRIG_OE == ($past(dir_ff) && $past(soft_mode)))
        else $error("driver enable wrong");
    a_term_select: assert property ( // [R8]
        TERM_50_EN == ($past(term_ff) && !$past(soft_mode)))
        else $error("termination select wrong");

    c_soft_go: cover property (state_ff == TRS_SETUP && soft_mode ##[1:20] go_ff);
    c_rise_go: cover property (mode_ff == TRS_RISING && go_ff);
    c_fall_go: cover property (mode_ff == TRS_FALLING && go_ff);
    c_force_go: cover property (state_ff == TRS_ARMED && force_wr ##1 go_ff);

endmodule // trs_trigger_select
`default_nettype wire

// File: bench/trs_ttl_src.sv
// Model of the external TTL trigger source on the shared connector.
`timescale 1ns/100ps
`default_nettype none
module trs_ttl_src
(
    input wire logic oe,
    input wire logic drv,
    output logic pin
);
    logic lvl = 1'b0;
    // Own copy of the split trigger; board drive wins while enabled
    assign pin = oe ? drv : lvl;
    task automatic put(input logic v);
        lvl = v;
    endtask
endmodule // trs_ttl_src
`default_nettype wire

// File: bench/replay_trigger_select_tb.sv
// Self-checking bench for the replay trigger selector.
`timescale 1ns/100ps
`default_nettype none
`include "trs_params.svh"
module replay_trigger_select_tb;
    import trs_pkg::*;
    // Short setup keeps the run brief
    localparam int SETUP = 1;
    // Two sync stages plus the trigger register, counted from the pin change
    localparam int EDGE_LAT = 3;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [7:0] ver = 8'h07;
    logic start = 1'b0;
    logic done = 1'b0;
    logic pre = 1'b0;
    logic [31:0] rdata;
    logic rvalid, trig_in, trig_out, trig_oe, term_en, go, armed;
    logic [31:0] codes [4] = '{`TRS_CODE_FREE_RUN, `TRS_CODE_RISING,
        `TRS_CODE_FALLING, `TRS_CODE_EITHER};
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;

    always #5 clk = ~clk;

    trs_trigger_select #(.SETUP_CYCLES(SETUP)) DUT (.CLK(clk), .RESET(rst), .REG_WR(wr),
        .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .BASE_VERSION(ver), .START(start), .REPLAY_DONE(done),
        .TRIG_IN(trig_in), .TRIG_OUT(trig_out), .TRIG_OE(trig_oe), .TERM_50_EN(term_en),
        .REPLAY_GO(go), .ARMED(armed));
    trs_ttl_src SRC (.oe(trig_oe), .drv(trig_out), .pin(trig_in));

    // ==========================================
    // Checking and access tasks
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    task automatic chkn(input int g, input int e);
        chk(32'(g), 32'(e));
    endtask
    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask
    task automatic rreg(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        #1;
        rd = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd = 1'b0;
        // Read data stands for one cycle only
        chk1(rvalid, 1'b1);
        chk(rdata, e);
    endtask
    // High selects START, low selects REPLAY_DONE
    task automatic kick(input logic which);
        @(posedge clk);
        #1;
        start = which;
        done = ~which;
        @(posedge clk);
        #1;
        start = 1'b0;
        done = 1'b0;
    endtask
    task automatic setin(input logic v);
        @(posedge clk);
        #1;
        SRC.put(v);
    endtask
    // Edges until REPLAY_GO: 0 if already high, -1 if never, -2 if unknown
    task automatic wgo(input int lim, output int k);
        k = -1;
        for (int i = 0; i <= lim && k == -1; i++)
        begin
            if (i > 0)
            begin
                @(posedge clk);
                #1;
            end
            if (go === 1'b1)
                k = i;
            else if (go !== 1'b0)
                k = -2;
        end
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            stop_test();
        end
    end

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        chk1(trig_oe, 1'b0);
        rreg(`TRS_REG_MODE, `TRS_CODE_FREE_RUN);
        rreg(`TRS_REG_DIRECTION, 32'h0);
        rreg(`TRS_REG_TERMINATION, 32'h0);
        rreg(32'h0000_0123, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            wreg(`TRS_REG_MODE, codes[m]);
            rreg(`TRS_REG_MODE, codes[m]);
            wreg(`TRS_REG_MODE, 32'h0000_4E34);
            rreg(`TRS_REG_MODE, codes[m]);
        end
        wreg(`TRS_REG_MODE, `TRS_CODE_FREE_RUN);
        wreg(`TRS_REG_COMMAND, `TRS_CMD_FORCE);
        wgo(4, n);
        chkn(n, -1);
        for (int d = 0; d < 2; d++)
        begin
            wreg(`TRS_REG_DIRECTION, 32'(d));
            kick(1'b1);
            chk1(trig_oe, d[0]);
            wgo(8, n);
            chkn(n, SETUP);
            chk1(trig_out, d[0]);
            setin(1'b0);
            chk1(trig_out, 1'b0);
            kick(1'b0);
        end
        // Direction stays 1 so edge modes must override it
        wreg(`TRS_REG_TERMINATION, 32'h1);
        for (int m = 1; m < 4; m++)
        begin
            pre = (m == 1);
            // Level set once the board has let go of the pin; its edge dies in setup
            wreg(`TRS_REG_MODE, codes[m]);
            setin(pre);
            kick(1'b1);
            chk1(trig_oe, 1'b0);
            chk1(term_en, 1'b1);
            wgo(4, n);
            chkn(n, -1);
            chk1(armed, 1'b1);
            if (m != 3)
            begin
                setin(~pre);
                wgo(6, n);
                chkn(n, -1);
            end
            setin(m == 3 ? 1'b1 : pre);
            wgo(8, n);
            chkn(n, EDGE_LAT);
            chk1(trig_out, 1'b0);
            chk1(armed, 1'b0);
            setin(1'b0);
            setin(1'b1);
            wgo(6, n);
            chkn(n, -1);
            kick(1'b0);
        end
        wreg(`TRS_REG_TERMINATION, 32'h0);
        kick(1'b1);
        chk1(term_en, 1'b0);
        wgo(4, n);
        chkn(n, -1);
        ver = 8'h06;
        wreg(`TRS_REG_COMMAND, `TRS_CMD_FORCE);
        wgo(3, n);
        chkn(n, -1);
        ver = 8'h07;
        wreg(`TRS_REG_COMMAND, 32'h0000_0011);
        wgo(3, n);
        chkn(n, -1);
        wreg(`TRS_REG_COMMAND, `TRS_CMD_FORCE);
        wgo(3, n);
        chkn(n, 0);
        // A second force while replay runs must stay silent
        wreg(`TRS_REG_COMMAND, `TRS_CMD_FORCE);
        wgo(3, n);
        chkn(n, -1);
        kick(1'b0);
        stop_test();
    end
endmodule // replay_trigger_select_tb
`default_nettype wire
